// ### bench/byte_hardware_multiplier_bench.sv
`timescale 1ns/1ps
module byte_hardware_multiplier_bench;
reg clk = 0, resetn = 0, mul = 0, wh = 0, wl = 0;
reg [7:0] w = 0, f = 0, wd = 0;
reg [4:0] st = 0;
wire [7:0] ph, pl;
wire [4:0] so;
wire pv;
int n_mismatch = 0, check_count = 0, cyc = 0;
reg [15:0] p_ll, p_hh, p_lh, p_hl;
reg [31:0] wide;
reg [7:0] sa = 8'hfd, sb = 8'h05;
reg [15:0] ua = 16'hfffe, ub = 16'h0003;
// each row: first operand, second operand, expected product
reg [31:0] rows [4] = '{32'hffff_fe01, 32'h8002_0100, 32'h0037_0000, 32'h0f11_00ff};
byte_hardware_multiplier DUT (.clk(clk), .resetn(resetn), .multiply_working_by_file(mul),
    .working_register(w), .file_operand(f), .write_product_high(wh), .write_product_low(wl),
    .write_data(wd), .status_in(st), .product_high(ph), .product_low(pl), .status_out(so),
    .product_valid(pv));
initial forever #2 clk = ~clk;
always @(posedge clk)
begin
    if (++cyc == 500)
    begin
        n_mismatch++;
        complete_run;
    end
end
task chk(string nm, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin n_mismatch++; $display("Error %s expected %h seen %h", nm, e, s); end
endtask
task op(logic m, h, l, logic [7:0] a, b);
    @(posedge clk) #1 {mul, wh, wl, w, f, wd} = {m, h, l, a, b, a};
    @(posedge clk) #1 {mul, wh, wl} = 0;
endtask
task mul8(input logic [7:0] a, b, output logic [15:0] p);
    op(1, 0, 0, a, b);
    p = {ph, pl};
endtask
// four byte products summed with their weights
task wide16(input logic [15:0] a, b);
    mul8(a[7:0], b[7:0], p_ll);
    mul8(a[15:8], b[15:8], p_hh);
    mul8(a[7:0], b[15:8], p_lh);
    mul8(a[15:8], b[7:0], p_hl);
    wide = {p_hh, p_ll} + {8'h00, p_lh, 8'h00} + {8'h00, p_hl, 8'h00};
endtask
task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial
begin
    repeat (12) @(posedge clk);
    #1 chk("reset pair", 0, {ph, pl});
    chk("reset valid", 0, pv);
    resetn = 1;
    $display("power-on reset done");
    foreach (rows[i])
    begin
        st = 5'(i + 9);
        op(1, 0, 0, rows[i][31:24], rows[i][23:16]);
        chk("product", rows[i][15:0], {ph, pl});
        chk("flags", st, so);
        chk("valid", 1, pv);
        $display("row %0d done", i);
    end
    op(0, 0, 0, 8'h00, 8'h00);
    chk("hold", 16'h00ff, {ph, pl});
    chk("valid", 0, pv);
    op(1, 1, 0, 8'h03, 8'h05);
    chk("multiply wins", 16'h000f, {ph, pl});
    op(0, 1, 1, 8'h5a, 8'h00);
    chk("write", 16'h5a5a, {ph, pl});
    $display("hold and write done");
    mul8(sa, sb, p_ll);
    if (sb[7]) p_ll[15:8] = p_ll[15:8] - sa;
    if (sa[7]) p_ll[15:8] = p_ll[15:8] - sb;
    chk("signed byte", 32'h0000_fff1, p_ll);
    $display("signed byte done");
    wide16(16'h1234, 16'h5678);
    chk("unsigned word", 32'h0626_0060, wide);
    $display("unsigned word done");
    wide16(ua, ub);
    if (ub[15]) wide[31:16] = wide[31:16] - ua;
    if (ua[15]) wide[31:16] = wide[31:16] - ub;
    chk("signed word", 32'hffff_fffa, wide);
    $display("signed word done");
    @(posedge clk) #1 resetn = 0;
    @(posedge clk) #1 chk("reset", 0, {ph, pl});
    chk("reset valid", 0, pv);
    chk("reset flags", 0, so);
    resetn = 1;
    op(1, 0, 0, 8'h10, 8'h10);
    chk("after reset", 16'h0100, {ph, pl});
    $display("awkward cases done");
    complete_run;
end
endmodule

// ### bench/mult_checker.sv
`timescale 1ns/1ps
module mult_checker (
    input wire clk,
    input wire resetn,
    input wire multiply_working_by_file,
    input wire [7:0] working_register,
    input wire [7:0] file_operand,
    input wire write_product_high,
    input wire write_product_low,
    input wire [7:0] write_data,
    input wire [4:0] status_in,
    input wire [7:0] product_high,
    input wire [7:0] product_low,
    input wire [4:0] status_out,
    input wire product_valid
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire mul = multiply_working_by_file;
wire idle = !mul && !write_product_high && !write_product_low;
sequence s_mul_req;
    mul;
endsequence
sequence s_mul_then_idle;
    mul ##1 !mul;
endsequence
AST_PROD: assert property (s_mul_req |=> {product_high, product_low} ==
    $past(working_register) * $past(file_operand)) else $error("bad product");
AST_VALID: assert property (1 |=> product_valid == $past(mul)) else $error("bad valid");
AST_FLAGS: assert property (1 |=> status_out == $past(status_in)) else $error("bad flags");
AST_HOLD: assert property (idle |=> $stable({product_high, product_low}))
    else $error("product moved");
AST_WRL: assert property (write_product_low && !mul |=> product_low == $past(write_data))
    else $error("bad low write");
AST_WRH: assert property (write_product_high && !mul |=> product_high == $past(write_data))
    else $error("bad high write");
AST_PULSE: assert property (s_mul_then_idle |=> !product_valid) else $error("valid stuck");
endmodule
bind byte_hardware_multiplier mult_checker chk (.*);

// ### rtl/byte_hardware_multiplier.v
// Summary of operation
// - unsigned 8x8 multiply; high byte to product_high, low byte to product_low.
// - a multiply leaves every status flag unchanged.
// - product is ready one cycle after the multiply, no stall.
// - operands are working_register and the addressed file value.
`timescale 1ns/1ps
`include "byte_mult_consts.vh"

module byte_hardware_multiplier #(
    parameter WIDTH = `OPERAND_WIDTH
) (
    input wire clk,
    input wire resetn,
    input wire multiply_working_by_file,
    input wire [WIDTH-1:0] working_register,
    input wire [WIDTH-1:0] file_operand,
    input wire write_product_high,
    input wire write_product_low,
    input wire [WIDTH-1:0] write_data,
    input wire [4:0] status_in,
    output reg [WIDTH-1:0] product_high,
    output reg [WIDTH-1:0] product_low,
    output reg [4:0] status_out,
    output reg product_valid
);

    ////////////////////////////////////////////////////////////////////
    // byte positions within the full product
    localparam PRODUCT_WIDTH = 2 * WIDTH;
    localparam HIGH_MSB = PRODUCT_WIDTH - 1;
    localparam HIGH_LSB = WIDTH;
    localparam LOW_MSB = WIDTH - 1;
    localparam LOW_LSB = `PROD_LOW_LSB;

    // where each product byte loads from
    localparam SRC_HOLD = 2'h0;
    localparam SRC_MULTIPLY = 2'h1;
    localparam SRC_WRITE = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // operands as seen by the multiplier
    wire [WIDTH-1:0] multiplicand_operand;
    wire [WIDTH-1:0] multiplier_operand;

    // product datapath signals
    wire [PRODUCT_WIDTH-1:0] full_product;
    wire [WIDTH-1:0] product_upper_byte;
    wire [WIDTH-1:0] product_lower_byte;

    // load source of each byte
    reg [1:0] high_source;
    reg [1:0] low_source;

    // next values of the output registers
    reg [WIDTH-1:0] product_high_next;
    reg [WIDTH-1:0] product_low_next;
    reg [4:0] status_next;
    reg product_valid_next;

    ////////////////////////////////////////////////////////////////////
    // working register and file
    assign multiplicand_operand = working_register;
    assign multiplier_operand = file_operand;

    ////////////////////////////////////////////////////////////////////
    // unsigned byte multiplier
    unsigned_byte_product #(
        .WIDTH(WIDTH)
    ) product_core (
        .multiplicand(multiplicand_operand),
        .multiplier(multiplier_operand),
        .product(full_product)
    );

    ////////////////////////////////////////////////////////////////////
    // split product bytes
    assign product_upper_byte = full_product[HIGH_MSB:HIGH_LSB];
    assign product_lower_byte = full_product[LOW_MSB:LOW_LSB];

    ////////////////////////////////////////////////////////////////////
    // multiply beats write
    // a write in a multiply cycle is dropped
    always @*
    begin
        high_source = SRC_HOLD;
        if (multiply_working_by_file)
        begin
            high_source = SRC_MULTIPLY;
        end
        else if (write_product_high)
        begin
            high_source = SRC_WRITE;
        end
    end

    // multiply beats write
    // a write in a multiply cycle is dropped
    always @*
    begin
        low_source = SRC_HOLD;
        if (multiply_working_by_file)
        begin
            low_source = SRC_MULTIPLY;
        end
        else if (write_product_low)
        begin
            low_source = SRC_WRITE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // upper product byte
    // hold is the default: product_high keeps its value
    always @*
    begin
        case (high_source)
            SRC_MULTIPLY:
            begin
                product_high_next = product_upper_byte;
            end
            SRC_WRITE:
            begin
                product_high_next = write_data;
            end
            default:
            begin
                product_high_next = product_high;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // lower product byte
    // hold is the default: product_low keeps its value
    always @*
    begin
        case (low_source)
            SRC_MULTIPLY:
            begin
                product_low_next = product_lower_byte;
            end
            SRC_WRITE:
            begin
                product_low_next = write_data;
            end
            default:
            begin
                product_low_next = product_low;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // flags pass untouched
    always @*
    begin
        status_next = status_in;
    end

    always @*
    begin
        product_valid_next = multiply_working_by_file;
    end

    ////////////////////////////////////////////////////////////////////
    // single cycle update
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            product_high <= `PROD_HIGH_RESET;
        end
        else
        begin
            product_high <= product_high_next;
        end
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            product_low <= `PROD_LOW_RESET;
        end
        else
        begin
            product_low <= product_low_next;
        end
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_out <= `STATUS_RESET;
        end
        else
        begin
            status_out <= status_next;
        end
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            product_valid <= `VALID_RESET;
        end
        else
        begin
            product_valid <= product_valid_next;
        end
    end

endmodule

// ### rtl/byte_mult_consts.vh
`ifndef BYTE_MULT_CONSTS_VH
`define BYTE_MULT_CONSTS_VH

// operand and product widths
`define OPERAND_WIDTH 8
`define PRODUCT_WIDTH 16
// product byte positions
`define PROD_HIGH_MSB 15
`define PROD_HIGH_LSB 8
`define PROD_LOW_MSB 7
`define PROD_LOW_LSB 0
// reset values of the product pair
`define PROD_HIGH_RESET 8'h00
`define PROD_LOW_RESET 8'h00
// reset values of the flag copy and the valid pulse
`define STATUS_RESET 5'h00
`define VALID_RESET 1'h0

`endif

// ### rtl/unsigned_byte_product.v
`timescale 1ns/1ps
// combinational unsigned product of two bytes
module unsigned_byte_product #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] multiplicand,
    input wire [WIDTH-1:0] multiplier,
    output wire [2*WIDTH-1:0] product
);

    wire [2*WIDTH-1:0] wide_multiplicand;
    wire [2*WIDTH-1:0] wide_multiplier;

    assign wide_multiplicand = {{WIDTH{1'b0}}, multiplicand};
    assign wide_multiplier = {{WIDTH{1'b0}}, multiplier};
    assign product = wide_multiplicand * wide_multiplier;

endmodule
